// *** design/card_cmd_pkg.sv ***
package card_cmd_pkg;

  // Clock and auto power-down time base.
  localparam int CLK_MHZ        = 100;
  localparam int PD_UNIT_US     = 5000;
  localparam int PD_TICK_CYCLES = PD_UNIT_US * CLK_MHZ;

  // Task-file register offsets.
  localparam logic [2:0] TF_DATA    = 3'h0;
  localparam logic [2:0] TF_FEATURE = 3'h1;
  localparam logic [2:0] TF_SEC_CNT = 3'h2;
  localparam logic [2:0] TF_SEC_NUM = 3'h3;
  localparam logic [2:0] TF_CYL_LO  = 3'h4;
  localparam logic [2:0] TF_CYL_HI  = 3'h5;
  localparam logic [2:0] TF_CDH     = 3'h6;
  localparam logic [2:0] TF_CMD     = 3'h7;

  // Command opcodes.
  localparam logic [7:0] OP_IDLE_A     = 8'h97;
  localparam logic [7:0] OP_IDLE_B     = 8'he3;
  localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] OP_IDLE_IMM_B = 8'he1;
  localparam logic [7:0] OP_INIT_PARAM = 8'h91;
  localparam logic [7:0] OP_KEY_MGMT   = 8'hb9;
  localparam logic [7:0] OP_SEC_UNLOCK = 8'hf2;
  localparam logic [7:0] OP_SEC_ERASE  = 8'hf4;

  // Status and error register bit positions.
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ   = 3;
  localparam int ST_ERR   = 0;
  localparam int ERR_ABRT = 2;

  // Identify word indices.
  localparam logic [7:0] ID_W_FEATURES = 8'h52;
  localparam logic [7:0] ID_W_ERASE    = 8'h59;
  localparam logic [7:0] ID_W_ENH_ERS  = 8'h5a;
  localparam logic [7:0] ID_W_APM      = 8'h5b;
  localparam logic [7:0] ID_W_SECURITY = 8'h80;
  localparam logic [7:0] ID_W_POWER    = 8'ha0;
  localparam logic [7:0] ID_W_KEY_MGMT = 8'ha2;

  // Identify field positions and fixed values.
  localparam int          W82_SEC      = 1;
  localparam logic [15:0] W82_FIXED    = 16'h7008;
  localparam int          SS_LEVEL     = 8;
  localparam int          SS_ENH       = 5;
  localparam int          SS_EXPIRE    = 4;
  localparam int          SS_FROZEN    = 3;
  localparam int          SS_LOCK      = 2;
  localparam int          SS_EN        = 1;
  localparam int          SS_CAP       = 0;
  localparam int          PR_VALID     = 15;
  localparam int          PR_RSV       = 14;
  localparam int          PR_NO_L1     = 13;
  localparam int          PR_L1_DIS    = 12;
  localparam int          KM_SCHEME0   = 0;
  localparam logic [7:0]  ERASE_TOP    = 8'hff;
  localparam logic [15:0] ERASE_LIMIT  = 16'h01fc;

  // Key-management structure transfer.
  localparam logic [7:0] KM_LAST_WORD = 8'hff;
  localparam int         KM_SUB_BIT   = 7;

  // Failed security attempts before the count expires.
  localparam logic [2:0] SEC_ATTEMPT_LIMIT = 3'h5;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sec_cnt;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] cdh;
  } task_file_type;

  localparam task_file_type TF_RESET = '0;

  typedef struct packed {
    logic supported;
    logic enabled;
    logic locked;
    logic frozen;
    logic level_max;
    logic enh_erase;
  } security_cfg_type;

  typedef struct packed {
    logic        valid;
    logic        no_level1_cmds;
    logic        level1_cmds_disabled;
    logic [11:0] max_current_ma;
  } power_cfg_type;

  typedef enum logic [2:0] {
    CMD_IDLE     = 3'b000,
    CMD_EXEC     = 3'b001,
    CMD_SEC_WAIT = 3'b010,
    CMD_XFER     = 3'b011,
    CMD_DONE     = 3'b100
  } cmd_state_type;

endpackage

// *** design/auto_power_down.sv ***
`timescale 1ns/1ps
module auto_power_down
  import card_cmd_pkg::*;
#(
  parameter int TICK_CYCLES = PD_TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control.
  input  wire logic       enable_i,
  input  wire logic [7:0] timeout_i,
  input  wire logic       restart_i,
  // State.
  output logic            standby_o
);

  localparam int              TICK_W    = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] tick_r;
  logic [7:0]        unit_r;
  logic              unit_end;

  assign unit_end = (tick_r == TICK_LAST);

  always_ff @(posedge clk_i)
  begin
    if (reset_i || restart_i || !enable_i || standby_o || unit_end)
      tick_r <= '0;
    else
      tick_r <= tick_r + TICK_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || restart_i || !enable_i)
      unit_r <= 8'h00;
    else if (unit_end && !standby_o)
      unit_r <= unit_r + 8'h01;
  end

  // Standby is entered once the armed number of 5 ms units has elapsed.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || restart_i || !enable_i)
      standby_o <= 1'b0;
    else if (unit_end && (unit_r + 8'h01 == timeout_i))
      standby_o <= 1'b1;
  end

endmodule

// *** design/card_power_security_cmds.sv ***
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module card_power_security_cmds
  import card_cmd_pkg::*;
#(
  parameter int PD_TICKS = PD_TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Task-file register port.
  input  wire logic [2:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  output logic                   intrq_o,
  // Identify word lookup.
  input  wire logic [7:0]        ident_index_i,
  output logic      [15:0]       ident_word_o,
  // Device configuration.
  input  wire security_cfg_type  sec_cfg_i,
  input  wire power_cfg_type     pwr_cfg_i,
  input  wire logic [7:0]        apm_level_i,
  input  wire logic [15:0]       erase_minutes_i,
  input  wire logic [15:0]       enh_erase_minutes_i,
  input  wire logic              km_scheme_i,
  // Security engine handshake.
  output logic                   sec_cmd_req_o,
  output logic      [7:0]        sec_cmd_code_o,
  input  wire logic              sec_cmd_done_i,
  input  wire logic              sec_cmd_fail_i,
  // Key-management structure source.
  output logic      [7:0]        km_word_index_o,
  input  wire logic [15:0]       km_word_i,
  output logic      [38:0]       host_challenge_value_o,
  // Power state and geometry.
  output logic                   idle_mode_o,
  output logic                   standby_o,
  output logic      [7:0]        sectors_per_track_o,
  output logic      [3:0]        max_head_o
);

  ////////////////////////////////////////////////////////////////////////////////

  task_file_type tf_r;
  cmd_state_type state_r;
  logic [7:0]    cmd_r;
  logic          busy_flag_r;
  logic          drq_r;
  logic          err_r;
  logic          abrt_r;
  logic          expired_r;
  logic [2:0]    attempts_r;
  logic          pd_enable_r;
  logic [7:0]    pd_timeout_r;
  logic          pd_restart_r;
  logic          cmd_wr;
  logic          status_rd;
  logic          data_rd;
  logic          is_idle;
  logic          is_idle_imm;
  logic          is_sec;
  logic          km_ok;
  logic [7:0]    status_byte;

  assign cmd_wr      = wr_i && (addr_i == TF_CMD) && (state_r == CMD_IDLE);
  assign status_rd   = rd_i && (addr_i == TF_CMD);
  assign data_rd     = rd_i && (addr_i == TF_DATA) && (state_r == CMD_XFER);
  assign is_idle     = (cmd_r == OP_IDLE_A) || (cmd_r == OP_IDLE_B);
  assign is_idle_imm = (cmd_r == OP_IDLE_IMM_A) || (cmd_r == OP_IDLE_IMM_B);
  assign is_sec      = (cmd_r == OP_SEC_UNLOCK) || (cmd_r == OP_SEC_ERASE);
  assign km_ok       = (cmd_r == OP_KEY_MGMT) && km_scheme_i
                       && !tf_r.feature[KM_SUB_BIT];

  always_comb
  begin
    status_byte          = 8'h00;
    status_byte[ST_BUSY] = busy_flag_r;
    status_byte[ST_READY] = !busy_flag_r;
    status_byte[ST_DRQ]  = drq_r;
    status_byte[ST_ERR]  = err_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Task-file registers; writes are ignored while a command runs.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tf_r <= TF_RESET;
    else if (wr_i && (state_r == CMD_IDLE))
    begin
      unique case (addr_i)
        TF_FEATURE: tf_r.feature <= wdata_i[7:0];
        TF_SEC_CNT: tf_r.sec_cnt <= wdata_i[7:0];
        TF_SEC_NUM: tf_r.sec_num <= wdata_i[7:0];
        TF_CYL_LO:  tf_r.cyl_lo  <= wdata_i[7:0];
        TF_CYL_HI:  tf_r.cyl_hi  <= wdata_i[7:0];
        TF_CDH:     tf_r.cdh     <= wdata_i[7:0];
        TF_DATA, TF_CMD: tf_r <= tf_r;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      unique case (addr_i)
        TF_DATA:    rdata_o <= data_rd ? km_word_i : 16'h0000;
        TF_FEATURE: rdata_o <= {13'h0000, abrt_r, 2'h0};
        TF_SEC_CNT: rdata_o <= {8'h00, tf_r.sec_cnt};
        TF_SEC_NUM: rdata_o <= {8'h00, tf_r.sec_num};
        TF_CYL_LO:  rdata_o <= {8'h00, tf_r.cyl_lo};
        TF_CYL_HI:  rdata_o <= {8'h00, tf_r.cyl_hi};
        TF_CDH:     rdata_o <= {8'h00, tf_r.cdh};
        TF_CMD:     rdata_o <= {8'h00, status_byte};
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cmd_r <= 8'h00;
    else if (cmd_wr)
      cmd_r <= wdata_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_r <= CMD_IDLE;
    else
    begin
      unique case (state_r)
        CMD_IDLE:
          if (cmd_wr)
            state_r <= CMD_EXEC;
        CMD_EXEC:
          if (is_sec && !expired_r)
            state_r <= CMD_SEC_WAIT;
          else if (km_ok)
            state_r <= CMD_XFER;
          else
            state_r <= CMD_DONE;
        CMD_SEC_WAIT:
          if (sec_cmd_done_i)
            state_r <= CMD_DONE;
        CMD_XFER:
          if (data_rd && (km_word_index_o == KM_LAST_WORD))
            state_r <= CMD_IDLE;
        CMD_DONE:
          state_r <= CMD_IDLE;
        default:
          state_r <= CMD_IDLE;
      endcase
    end
  end

  // Busy rises with the command and falls as the interrupt is raised.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      busy_flag_r <= 1'b0;
    else if (cmd_wr)
      busy_flag_r <= 1'b1;
    else if ((state_r == CMD_DONE) || ((state_r == CMD_EXEC) && km_ok))
      busy_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      drq_r <= 1'b0;
    else if ((state_r == CMD_EXEC) && km_ok)
      drq_r <= 1'b1;
    else if (data_rd && (km_word_index_o == KM_LAST_WORD))
      drq_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      km_word_index_o <= 8'h00;
    else if (state_r == CMD_EXEC)
      km_word_index_o <= 8'h00;
    else if (data_rd)
      km_word_index_o <= km_word_index_o + 8'h01;
  end

  // Error and abort: anything other than the handled opcodes is refused.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      err_r  <= 1'b0;
      abrt_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      err_r  <= 1'b0;
      abrt_r <= 1'b0;
    end
    else if (state_r == CMD_EXEC)
    begin
      if (!(is_idle || is_idle_imm || (cmd_r == OP_INIT_PARAM) || km_ok
            || (is_sec && !expired_r)))
      begin
        err_r  <= 1'b1;
        abrt_r <= 1'b1;
      end
    end
    else if ((state_r == CMD_SEC_WAIT) && sec_cmd_done_i && sec_cmd_fail_i)
    begin
      err_r  <= 1'b1;
      abrt_r <= 1'b1;
    end
  end

  // A finishing command outranks a status read that would clear the line.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      intrq_o <= 1'b0;
    else if ((state_r == CMD_DONE) || ((state_r == CMD_EXEC) && km_ok))
      intrq_o <= 1'b1;
    else if (status_rd)
      intrq_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Security attempt counting; only a reset clears the expiry.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      attempts_r <= 3'h0;
    else if ((state_r == CMD_SEC_WAIT) && sec_cmd_done_i && sec_cmd_fail_i
             && (attempts_r != SEC_ATTEMPT_LIMIT))
      attempts_r <= attempts_r + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      expired_r <= 1'b0;
    else if (attempts_r == SEC_ATTEMPT_LIMIT)
      expired_r <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sec_cmd_req_o  <= 1'b0;
      sec_cmd_code_o <= 8'h00;
    end
    else
    begin
      sec_cmd_req_o <= (state_r == CMD_EXEC) && is_sec && !expired_r;
      if ((state_r == CMD_EXEC) && is_sec)
        sec_cmd_code_o <= cmd_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command effects.

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sectors_per_track_o <= 8'h00;
      max_head_o          <= 4'h0;
    end
    else if ((state_r == CMD_EXEC) && (cmd_r == OP_INIT_PARAM))
    begin
      sectors_per_track_o <= tf_r.sec_cnt;
      max_head_o          <= tf_r.cdh[3:0];
    end
  end

  // The challenge is taken as written; no value is refused.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      host_challenge_value_o <= 39'h0;
    else if ((state_r == CMD_EXEC) && km_ok)
      host_challenge_value_o <= {tf_r.feature[6:0], tf_r.sec_cnt, tf_r.sec_num,
                                 tf_r.cyl_lo, tf_r.cyl_hi};
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      idle_mode_o  <= 1'b0;
      pd_enable_r  <= 1'b0;
      pd_timeout_r <= 8'h00;
      pd_restart_r <= 1'b0;
    end
    else
    begin
      pd_restart_r <= cmd_wr;
      if ((state_r == CMD_EXEC) && (is_idle || is_idle_imm))
        idle_mode_o <= 1'b1;
      if ((state_r == CMD_EXEC) && is_idle)
      begin
        pd_enable_r  <= (tf_r.sec_cnt != 8'h00);
        pd_timeout_r <= tf_r.sec_cnt;
      end
    end
  end

  auto_power_down #(
    .TICK_CYCLES (PD_TICKS)
  ) u_apd (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .enable_i  (pd_enable_r),
    .timeout_i (pd_timeout_r),
    .restart_i (pd_restart_r),
    .standby_o (standby_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Identify words.

  function automatic logic [7:0] erase_code(input logic [15:0] minutes);
    logic [16:0] rounded;
    rounded = {1'b0, minutes} + 17'h00001;
    if (minutes == 16'h0000)
      erase_code = 8'h00;
    else if (minutes > ERASE_LIMIT)
      erase_code = ERASE_TOP;
    else
      erase_code = rounded[8:1];
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ident_word_o <= 16'h0000;
    else
    begin
      ident_word_o <= 16'h0000;
      unique case (ident_index_i)
        ID_W_FEATURES:
        begin
          ident_word_o          <= W82_FIXED;
          ident_word_o[W82_SEC] <= sec_cfg_i.supported;
        end
        ID_W_ERASE:   ident_word_o <= {8'h00, erase_code(erase_minutes_i)};
        ID_W_ENH_ERS: ident_word_o <= {8'h00, erase_code(enh_erase_minutes_i)};
        ID_W_APM:     ident_word_o <= {8'h00, apm_level_i};
        ID_W_SECURITY:
        begin
          ident_word_o[SS_LEVEL]  <= sec_cfg_i.enabled && sec_cfg_i.level_max;
          ident_word_o[SS_ENH]    <= sec_cfg_i.enh_erase;
          ident_word_o[SS_EXPIRE] <= expired_r;
          ident_word_o[SS_FROZEN] <= sec_cfg_i.frozen;
          ident_word_o[SS_LOCK]   <= sec_cfg_i.locked;
          ident_word_o[SS_EN]     <= sec_cfg_i.enabled;
          ident_word_o[SS_CAP]    <= sec_cfg_i.supported;
        end
        ID_W_POWER:
        begin
          ident_word_o[PR_VALID]  <= pwr_cfg_i.valid;
          ident_word_o[PR_RSV]    <= 1'b0;
          ident_word_o[PR_NO_L1]  <= pwr_cfg_i.no_level1_cmds;
          ident_word_o[PR_L1_DIS] <= pwr_cfg_i.level1_cmds_disabled;
          ident_word_o[11:0]      <= pwr_cfg_i.max_current_ma;
        end
        ID_W_KEY_MGMT: ident_word_o[KM_SCHEME0] <= km_scheme_i;
        default: ident_word_o <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence busy_then_done;
    busy_flag_r ##1 busy_flag_r ##1 (!busy_flag_r && intrq_o);
  endsequence

  idle_sequence_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_wr && ((wdata_i[7:0] == OP_IDLE_A) || (wdata_i[7:0] == OP_IDLE_B))
    |=> busy_then_done ##0 idle_mode_o)
    else $error("idle command sequence wrong");

  idle_imm_seq_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_wr && ((wdata_i[7:0] == OP_IDLE_IMM_A) || (wdata_i[7:0] == OP_IDLE_IMM_B))
    |=> busy_then_done ##0 idle_mode_o)
    else $error("idle immediate sequence wrong");

  apd_arm_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CMD_EXEC) && is_idle
    |=> (pd_enable_r == ($past(tf_r.sec_cnt) != 8'h00)) && (pd_timeout_r == $past(tf_r.sec_cnt)))
    else $error("auto power-down not armed from count");

  expire_abort_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_wr && expired_r && (wdata_i[7:0] == OP_SEC_UNLOCK)
    |=> ##1 !sec_cmd_req_o ##1 (err_r && abrt_r && intrq_o))
    else $error("expired unlock not aborted");

  geometry_take_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CMD_EXEC) && (cmd_r == OP_INIT_PARAM)
    |=> (sectors_per_track_o == $past(tf_r.sec_cnt)) && (max_head_o == $past(tf_r.cdh[3:0])))
    else $error("geometry not adopted");

  km_abort_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_wr && (wdata_i[7:0] == OP_KEY_MGMT) && !km_scheme_i
    |=> ##2 (err_r && abrt_r && intrq_o && !drq_r))
    else $error("structure read without scheme not aborted");

  km_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CMD_EXEC) && km_ok |=> drq_r && !busy_flag_r && (km_word_index_o == 8'h00))
    else $error("structure read did not start");

  sec_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ident_index_i == ID_W_SECURITY
    |=> ident_word_o[SS_LEVEL] == $past(sec_cfg_i.enabled && sec_cfg_i.level_max))
    else $error("security level bit wrong");

  power_rsv_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ident_index_i == ID_W_POWER
    |=> !ident_word_o[PR_RSV] && (ident_word_o[11:0] == $past(pwr_cfg_i.max_current_ma)))
    else $error("power word wrong");

  erase_top_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ident_index_i == ID_W_ERASE) && (erase_minutes_i > ERASE_LIMIT)
    |=> ident_word_o == 16'h00ff)
    else $error("long erase time not top code");

endmodule

// *** tb/card_side_model.sv ***
`timescale 1ns/1ps
module card_side_model
  import card_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Security engine.
  input  wire logic        sec_cmd_req_i,
  input  wire logic        fail_mode_i,
  output logic             sec_cmd_done_o,
  output logic             sec_cmd_fail_o,
  // Structure source.
  input  wire logic [7:0]  km_word_index_i,
  output logic      [15:0] km_word_o
);
  logic [2:0] wait_r;
  // Each word carries its own index, so a skipped or repeated read shows.
  assign km_word_o = {8'ha5, km_word_index_i};
  // The engine answers three cycles after a forwarded command.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      wait_r <= 3'h0;
    else if (sec_cmd_req_i)
      wait_r <= 3'h3;
    else if (wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
  end
  assign sec_cmd_done_o = (wait_r == 3'h1);
  assign sec_cmd_fail_o = sec_cmd_done_o & fail_mode_i;
endmodule

// *** tb/card_power_security_cmds_tb.sv ***
`timescale 1ns/1ps
module card_power_security_cmds_tb import card_cmd_pkg::*;;
  logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, fail_m = 1, km_s = 1;
  logic [2:0]  addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, ident_o, km_w, ers = 16'h0064, enh = 16'h0258, s;
  logic [7:0]  idx = 0, km_i, spt, code;
  logic [3:0]  head;
  logic [38:0] chal;
  logic        intrq_o, req, done, fail, idle_m, stby;
  security_cfg_type sec = 6'b110111;
  power_cfg_type    pwr = {1'b1, 1'b0, 1'b1, 12'h123};
  int n_mismatch = 0, tests_run = 0, n_req = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (req === 1'b1) n_req <= n_req + 1;
  card_power_security_cmds #(.PD_TICKS(4)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .intrq_o(intrq_o), .ident_index_i(idx), .ident_word_o(ident_o), .sec_cfg_i(sec),
    .pwr_cfg_i(pwr), .apm_level_i(8'h80), .erase_minutes_i(ers), .enh_erase_minutes_i(enh),
    .km_scheme_i(km_s), .sec_cmd_req_o(req), .sec_cmd_code_o(code), .sec_cmd_done_i(done),
    .sec_cmd_fail_i(fail), .km_word_index_o(km_i), .km_word_i(km_w),
    .host_challenge_value_o(chal), .idle_mode_o(idle_m), .standby_o(stby),
    .sectors_per_track_o(spt), .max_head_o(head));
  card_side_model u_side (.clk_i(clk_i), .reset_i(reset_i), .sec_cmd_req_i(req),
    .fail_mode_i(fail_m), .sec_cmd_done_o(done), .sec_cmd_fail_o(fail),
    .km_word_index_i(km_i), .km_word_o(km_w));
  task results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [38:0] got, input logic [38:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task idw(input logic [7:0] i, input logic [15:0] e);
    @(posedge clk_i);
    idx <= i;
    @(posedge clk_i);
    #1 chk("ident word", ident_o, e);
  endtask
  // Issues a command, waits for its interrupt and reads the status.
  task run(input logic [7:0] op);
    wr(TF_CMD, {8'h00, op});
    for (int i = 0; i < 60 && intrq_o !== 1'b1; i++) @(posedge clk_i);
    chk("intrq", intrq_o, 1'b1);
    rd(TF_CMD, s);
    chk("intrq cleared", intrq_o, 1'b0);
  endtask
  task cmd(input logic [7:0] op, input logic err);
    run(op);
    chk("status err", s[ST_ERR], err);
    if (err)
    begin
      rd(TF_FEATURE, s);
      chk("abort bit", s[ERR_ABRT], 1'b1);
    end
  endtask
  task t_ident;
    idw(ID_W_FEATURES, 16'h700a);
    idw(ID_W_ERASE, 16'h0032);
    idw(ID_W_ENH_ERS, 16'h00ff);
    idw(ID_W_APM, 16'h0080);
    idw(ID_W_SECURITY, 16'h012b);
    idw(ID_W_POWER, 16'h9123);
    idw(ID_W_KEY_MGMT, 16'h0001);
    @(posedge clk_i);
    sec <= 6'b110101;
    ers <= 16'h0000;
    enh <= 16'h01fc;
    pwr <= {1'b1, 1'b1, 1'b0, 12'hfed};
    idw(ID_W_SECURITY, 16'h002b);
    idw(ID_W_ERASE, 16'h0000);
    idw(ID_W_ENH_ERS, 16'h00fe);
    idw(ID_W_POWER, 16'hafed);
  endtask
  task t_idle;
    wr(TF_SEC_CNT, 16'h0002);
    cmd(OP_IDLE_A, 1'b0);
    chk("idle mode", idle_m, 1'b1);
    for (int i = 0; i < 40 && stby !== 1'b1; i++) @(posedge clk_i);
    chk("standby", stby, 1'b1);
    wr(TF_SEC_CNT, 16'h0000);
    cmd(OP_IDLE_B, 1'b0);
    repeat (30) @(posedge clk_i);
    chk("standby off", stby, 1'b0);
    cmd(OP_IDLE_IMM_A, 1'b0);
    cmd(OP_IDLE_IMM_B, 1'b0);
    chk("idle mode", idle_m, 1'b1);
  endtask
  task t_geom;
    wr(TF_CYL_LO, 16'h0077);
    wr(TF_SEC_CNT, 16'h0011);
    wr(TF_CDH, 16'h00a5);
    cmd(OP_INIT_PARAM, 1'b0);
    chk("sectors", spt, 8'h11);
    chk("max head", head, 4'h5);
  endtask
  task t_km;
    wr(TF_FEATURE, 16'h0055);
    wr(TF_SEC_CNT, 16'h0012);
    wr(TF_SEC_NUM, 16'h0034);
    wr(TF_CYL_LO, 16'h0056);
    wr(TF_CYL_HI, 16'h0078);
    cmd(OP_KEY_MGMT, 1'b0);
    chk("drq", s[ST_DRQ], 1'b1);
    chk("challenge", chal, {7'h55, 32'h12345678});
    for (int i = 0; i < 256; i++)
    begin
      rd(TF_DATA, s);
      chk("km word", s, {8'ha5, i[7:0]});
    end
    rd(TF_CMD, s);
    chk("drq end", s[ST_DRQ], 1'b0);
    wr(TF_FEATURE, 16'h0080);
    cmd(OP_KEY_MGMT, 1'b1);
    km_s <= 1'b0;
    wr(TF_FEATURE, 16'h0000);
    cmd(OP_KEY_MGMT, 1'b1);
    idw(ID_W_KEY_MGMT, 16'h0000);
    km_s <= 1'b1;
    cmd(8'h00, 1'b1);
  endtask
  task t_sec;
    fail_m <= 1'b0;
    cmd(OP_SEC_UNLOCK, 1'b0);
    chk("engine code", code, OP_SEC_UNLOCK);
    fail_m <= 1'b1;
    repeat (5) run(OP_SEC_UNLOCK);
    chk("engine requests", n_req, 6);
    idw(ID_W_SECURITY, 16'h003b);
    cmd(OP_SEC_ERASE, 1'b1);
    cmd(OP_SEC_UNLOCK, 1'b1);
    chk("engine requests", n_req, 6);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    idw(ID_W_SECURITY, 16'h002b);
    chk("idle mode reset", idle_m, 1'b0);
    cmd(OP_IDLE_IMM_B, 1'b0);
    chk("idle mode", idle_m, 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_ident;
    t_idle;
    t_geom;
    t_km;
    t_sec;
    results;
  end
  initial
  begin
    #500000;
    n_mismatch++;
    results;
  end
endmodule
